// *** inc/ipi_match_pkg.sv ***
/*
 * Shared constants and carriers for the inter-processor interrupt
 * destination matcher: register map, field positions, reset values,
 * delivery encodings and the message carried on the peer message bus.
 * Assumes one clock domain shared by the matcher and the message bus.
 */
package ipi_match_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] OFF_LOCAL_ID   = 8'h00;
    localparam logic [7:0] OFF_LOGIC_DEST = 8'h04;
    localparam logic [7:0] OFF_DEST_FMT   = 8'h08;
    localparam logic [7:0] OFF_CMD_LOW    = 8'h0C;
    localparam logic [7:0] OFF_CMD_HIGH   = 8'h10;
    localparam logic [7:0] OFF_STATUS     = 8'h14;

    // ==========================================================
    // Reset values
    localparam logic [31:0] RST_LOCAL_ID   = 32'h0000_0000;
    localparam logic [31:0] RST_LOGIC_DEST = 32'h0000_0000;
    localparam logic [31:0] RST_DEST_FMT   = 32'hFFFF_FFFF;
    localparam logic [31:0] RST_CMD        = 32'h0000_0000;

    // ==========================================================
    // Field positions
    localparam int LOGIC_ID_LSB  = 24;
    localparam int FMT_MODEL_LSB = 28;
    localparam int CMD_VEC_LSB  = 0;
    localparam int CMD_DLV_LSB  = 8;
    localparam int CMD_DMODE    = 11;
    localparam int CMD_LEVEL    = 14;
    localparam int CMD_TRIG     = 15;
    localparam int CMD_SH_LSB   = 18;
    localparam int CMD_DEST_LSB = 24;

    localparam logic [3:0] MODEL_FLAT    = 4'hF;
    localparam logic [3:0] MODEL_CLUSTER = 4'h0;

    // ==========================================================
    // Encodings
    localparam logic [2:0] DLV_FIXED    = 3'h0;
    localparam logic [2:0] DLV_LOWEST   = 3'h1;
    localparam logic [2:0] DLV_SYS_MGMT = 3'h2;
    localparam logic [2:0] DLV_NMI      = 3'h4;
    localparam logic [2:0] DLV_INIT     = 3'h5;
    localparam logic [2:0] DLV_STARTUP  = 3'h6;

    localparam logic [1:0] SH_NONE     = 2'h0;
    localparam logic [1:0] SH_SELF     = 2'h1;
    localparam logic [1:0] SH_ALL_INCL = 2'h2;
    localparam logic [1:0] SH_ALL_EXCL = 2'h3;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // Message on the peer bus
    typedef struct packed {
        logic [1:0] shorthand;
        logic       dest_mode;
        logic [7:0] dest;
        logic [2:0] delivery;
        logic       trig_level;
        logic       level;
        logic [7:0] vector;
        logic [7:0] source_id;
    } ipi_msg_t;

endpackage

// *** logic/ipi_destination_match.sv ***
/*
 * Destination selection and acceptance for inter-processor interrupt
 * messages in one local interrupt unit. Software programs the unit over
 * AXI4-Lite; a write to the low command word sends a message, and every
 * message seen on the peer bus is accepted or discarded one cycle later.
 * Assumes the peer message bus runs on aclk and delivers every message,
 * including this unit's own, to msg_in.
 */
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps

// Behaviour
// - Flagged level combos are sent edge triggered.
// - Startup-reset level 0 sends deassert, else edge.
// - Shorthand sends carry physical mode and broadcast address.
// - Physical: 00-FE one unit, FF broadcast.
// - Older bus: 0-0E one unit, 0F broadcast.
// - Logical mode carries 8-bit address, receivers compare; with LEGACY_BUS the code sends only bits 56-59, upper nibble zero.
// - Logical register holds 8-bit logical identifier.
// - Format register holds 4-bit model field.
// - Flat: accept when address AND identifier nonzero.
// - Flat: all-ones address reaches every unit.
// - Model 0000 selects the cluster model.
// - Cluster: compare cluster nibble and member bits.
// - Cluster: all-ones address matches every unit.
// - Format register resets to the flat model.
// - Nonzero shorthand ignores destination mode.
// - Destination field used only with no shorthand.
// - Physical target in high bits 56 to 63.
module ipi_destination_match
    import ipi_match_pkg::*;
#(
    parameter bit LEGACY_BUS = 1'b0
) (
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // AXI4-Lite write address and data
    input  wire logic       awvalid,
    output logic            awready,
    input  wire logic [7:0] awaddr,
    input  wire logic       wvalid,
    output logic            wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic            bvalid,
    input  wire logic       bready,
    output logic [1:0]      bresp,
    // AXI4-Lite read
    input  wire logic       arvalid,
    output logic            arready,
    input  wire logic [7:0] araddr,
    output logic            rvalid,
    input  wire logic       rready,
    output logic [31:0]     rdata,
    output logic [1:0]      rresp,
    // Outgoing message
    output logic            msg_out_valid,
    output ipi_msg_t        msg_out,
    // Incoming message and decision
    input  wire logic       msg_in_valid,
    input  wire ipi_msg_t   msg_in,
    output logic            accept_pulse,
    output logic            discard_pulse,
    output ipi_msg_t        accepted_msg
);

    // ==========================================================
    // Registers
    logic [31:0] local_id_reg_r;
    logic [31:0] logical_destination_reg_r;
    logic [31:0] destination_format_reg_r;
    logic [31:0] cmd_low_r;
    logic [31:0] cmd_high_r;
    logic [7:0]  sent_count_r;
    logic [7:0]  accept_count_r;
    logic        last_accept_r;

    logic        aw_hold_r;
    logic        w_hold_r;
    logic [7:0]  awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;

    logic        send_r;
    ipi_msg_t    msg_out_r;
    logic        accept_r;
    logic        discard_r;
    ipi_msg_t    accepted_r;

    logic        do_write;
    logic [31:0] cmd_low_nxt;
    logic [7:0]  own_id;
    logic [7:0]  bcast_id;
    logic        match;

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return a == OFF_LOCAL_ID || a == OFF_LOGIC_DEST || a == OFF_DEST_FMT
            || a == OFF_CMD_LOW || a == OFF_CMD_HIGH || a == OFF_STATUS;
    endfunction

    // ==========================================================
    // AXI4-Lite write channel
    // Address and data are caught independently; the write happens
    // once both are held, so either order is taken.
    assign awready  = !aw_hold_r && !bvalid_r;
    assign wready   = !w_hold_r && !bvalid_r;
    assign do_write = aw_hold_r && w_hold_r;
    assign bvalid   = bvalid_r;
    assign bresp    = bresp_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            awaddr_r  <= 8'h00;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_hold_r <= 1'b1;
                awaddr_r  <= awaddr;
            end else if (do_write) begin
                aw_hold_r <= 1'b0;
            end
            if (wvalid && wready) begin
                w_hold_r <= 1'b1;
                wdata_r  <= wdata;
                wstrb_r  <= wstrb;
            end else if (do_write) begin
                w_hold_r <= 1'b0;
            end
            if (do_write) begin
                bvalid_r <= 1'b1;
                bresp_r  <= mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
            end else if (bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            local_id_reg_r            <= RST_LOCAL_ID;
            logical_destination_reg_r <= RST_LOGIC_DEST;
            destination_format_reg_r  <= RST_DEST_FMT;
            cmd_high_r                <= RST_CMD;
        end else if (do_write) begin
            unique case (awaddr_r)
                OFF_LOCAL_ID: begin
                    local_id_reg_r <= merge(local_id_reg_r, wdata_r, wstrb_r) & 32'h0000_00FF;
                end
                OFF_LOGIC_DEST: begin
                    // Only the 8-bit identifier is kept.
                    logical_destination_reg_r <= merge(logical_destination_reg_r, wdata_r, wstrb_r)
                                                 & 32'hFF00_0000;
                end
                OFF_DEST_FMT: begin
                    // Only the model nibble is writable; the rest reads as ones.
                    destination_format_reg_r <= merge(destination_format_reg_r, wdata_r, wstrb_r)
                                                | 32'h0FFF_FFFF;
                end
                OFF_CMD_HIGH: begin
                    cmd_high_r <= merge(cmd_high_r, wdata_r, wstrb_r) & 32'hFF00_0000;
                end
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // Command register and message forming
    assign cmd_low_nxt = merge(cmd_low_r, wdata_r, wstrb_r);
    assign own_id      = LEGACY_BUS ? {4'h0, local_id_reg_r[3:0]} : local_id_reg_r[7:0];
    assign bcast_id    = LEGACY_BUS ? 8'h0F : 8'hFF;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd_low_r    <= RST_CMD;
            send_r       <= 1'b0;
            msg_out_r    <= '0;
            sent_count_r <= 8'h00;
        end else begin
            send_r <= do_write && awaddr_r == OFF_CMD_LOW;
            if (do_write && awaddr_r == OFF_CMD_LOW) begin
                cmd_low_r              <= cmd_low_nxt;
                sent_count_r           <= sent_count_r + 8'h01;
                msg_out_r.shorthand    <= cmd_low_nxt[CMD_SH_LSB +: 2];
                msg_out_r.delivery     <= cmd_low_nxt[CMD_DLV_LSB +: 3];
                msg_out_r.vector       <= cmd_low_nxt[CMD_VEC_LSB +: 8];
                msg_out_r.level        <= cmd_low_nxt[CMD_LEVEL];
                msg_out_r.source_id    <= own_id;
                // Level trigger survives only as the startup-reset deassert;
                // every other level request goes out edge triggered.
                msg_out_r.trig_level   <= cmd_low_nxt[CMD_DLV_LSB +: 3] == DLV_INIT
                                          && !cmd_low_nxt[CMD_LEVEL];
                if (cmd_low_nxt[CMD_SH_LSB +: 2] == SH_NONE) begin
                    msg_out_r.dest_mode <= cmd_low_nxt[CMD_DMODE];
                    msg_out_r.dest      <= LEGACY_BUS ? {4'h0, cmd_high_r[CMD_DEST_LSB +: 4]}
                                                      : cmd_high_r[CMD_DEST_LSB +: 8];
                end else begin
                    // Shorthand replaces mode and field with a physical broadcast.
                    msg_out_r.dest_mode <= 1'b0;
                    msg_out_r.dest      <= bcast_id;
                end
            end
        end
    end

    assign msg_out_valid = send_r;
    assign msg_out       = msg_out_r;

    // ==========================================================
    // Acceptance
    logic [7:0] logical_id;
    logic [3:0] model;
    assign logical_id = logical_destination_reg_r[LOGIC_ID_LSB +: 8];
    assign model      = destination_format_reg_r[FMT_MODEL_LSB +: 4];

    always_comb begin
        match = 1'b0;
        unique case (msg_in.shorthand)
            SH_SELF:     match = msg_in.source_id == own_id;
            SH_ALL_INCL: match = 1'b1;
            SH_ALL_EXCL: match = msg_in.source_id != own_id;
            SH_NONE: begin
                if (!msg_in.dest_mode) begin
                    if (LEGACY_BUS) begin
                        match = msg_in.dest[3:0] == 4'hF
                                || msg_in.dest[3:0] == local_id_reg_r[3:0];
                    end else begin
                        match = msg_in.dest == 8'hFF || msg_in.dest == own_id;
                    end
                end else if (model == MODEL_FLAT) begin
                    match = msg_in.dest == 8'hFF
                            || (msg_in.dest & logical_id) != 8'h00;
                end else if (model == MODEL_CLUSTER) begin
                    match = msg_in.dest == 8'hFF
                            || (msg_in.dest[7:4] == logical_id[7:4]
                                && (msg_in.dest[3:0] & logical_id[3:0]) != 4'h0);
                end
            end
        endcase
    end

    // Any other model code discards logical messages rather than guessing.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            accept_r       <= 1'b0;
            discard_r      <= 1'b0;
            accepted_r     <= '0;
            accept_count_r <= 8'h00;
            last_accept_r  <= 1'b0;
        end else begin
            accept_r  <= msg_in_valid && match;
            discard_r <= msg_in_valid && !match;
            if (msg_in_valid) begin
                last_accept_r <= match;
            end
            if (msg_in_valid && match) begin
                accepted_r     <= msg_in;
                accept_count_r <= accept_count_r + 8'h01;
            end
        end
    end

    assign accept_pulse  = accept_r;
    assign discard_pulse = discard_r;
    assign accepted_msg  = accepted_r;

    // ==========================================================
    // AXI4-Lite read channel
    assign arready = !rvalid_r;
    assign rvalid  = rvalid_r;
    assign rdata   = rdata_r;
    assign rresp   = rresp_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid_r <= 1'b1;
            rresp_r  <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (araddr)
                OFF_LOCAL_ID:   rdata_r <= local_id_reg_r;
                OFF_LOGIC_DEST: rdata_r <= logical_destination_reg_r;
                OFF_DEST_FMT:   rdata_r <= destination_format_reg_r;
                OFF_CMD_LOW:    rdata_r <= cmd_low_r;
                OFF_CMD_HIGH:   rdata_r <= cmd_high_r;
                OFF_STATUS:     rdata_r <= {15'h0000, last_accept_r, accept_count_r, sent_count_r};
                default:        rdata_r <= 32'h0000_0000;
            endcase
        end else if (rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic plain_in;
    assign plain_in = msg_in_valid && msg_in.shorthand == SH_NONE;

    phys_bcast_a: assert property (plain_in && !msg_in.dest_mode && msg_in.dest == bcast_id
        |=> accept_pulse) else $error("physical broadcast not accepted");
    flat_match_a: assert property (plain_in && msg_in.dest_mode && model == MODEL_FLAT
        && (msg_in.dest & logical_id) != 8'h00 |=> accept_pulse && accepted_msg == $past(msg_in))
        else $error("flat overlap not accepted");
    cluster_miss_a: assert property (plain_in && msg_in.dest_mode && model == MODEL_CLUSTER
        && msg_in.dest != 8'hFF && msg_in.dest[7:4] != logical_id[7:4] |=> discard_pulse)
        else $error("foreign cluster accepted");
    cluster_bcast_a: assert property (plain_in && msg_in.dest_mode && model == MODEL_CLUSTER
        && msg_in.dest == 8'hFF |=> accept_pulse) else $error("cluster broadcast missed");
    one_decision_a: assert property (msg_in_valid |=> (accept_pulse ^ discard_pulse)
        ##1 !(accept_pulse || discard_pulse) || $past(msg_in_valid))
        else $error("decision count wrong");
    reset_flat_a: assert property (disable iff (1'b0) !aresetn |=> model == MODEL_FLAT)
        else $error("format not flat after reset");
    shorthand_dest_a: assert property (msg_out_valid && msg_out.shorthand != SH_NONE
        |-> !msg_out.dest_mode && msg_out.dest == bcast_id) else $error("shorthand kept destination");
    trig_edge_a: assert property (msg_out_valid |-> msg_out.trig_level
        == (msg_out.delivery == DLV_INIT && !msg_out.level)) else $error("trigger not forced");
    send_after_cmd_a: assert property (do_write && awaddr_r == OFF_CMD_LOW
        |=> msg_out_valid ##1 !msg_out_valid) else $error("command write did not send once");

    flat_accept_c:    cover property (plain_in && msg_in.dest_mode && model == MODEL_FLAT ##1 accept_pulse);
    cluster_accept_c: cover property (plain_in && msg_in.dest_mode && model == MODEL_CLUSTER ##1 accept_pulse);
    self_c:           cover property (msg_in_valid && msg_in.shorthand == SH_SELF ##1 accept_pulse);
    send_c:           cover property (msg_out_valid && msg_out.delivery == DLV_INIT && msg_out.trig_level);

endmodule

// *** verif/peer_unit.sv ***
/*
 * Model of the peer units that share the message bus with the matcher.
 * Assumes the bench calls send and idle from its own sequence on aclk.
 */
`timescale 1ns/1ps
module peer_unit
    import ipi_match_pkg::*;
(
    // Clock
    input  wire logic aclk,
    // Message bus
    output logic      msg_in_valid,
    output ipi_msg_t  msg_in
);
    // ==========================================================
    // Bus driver
    ipi_msg_t last;

    initial begin
        msg_in_valid = 1'b0;
        msg_in       = '0;
        last         = '0;
    end

    // Valid stays high across back-to-back sends; only idle drops it.
    task automatic send(input ipi_msg_t m);
        @(posedge aclk);
        msg_in_valid <= 1'b1;
        msg_in       <= m;
        last = m;
    endtask

    // A released bus shows the inverse of the last message; with valid low the matcher makes no decision on it.
    task automatic idle();
        @(posedge aclk);
        msg_in_valid <= 1'b0;
        msg_in       <= ~last;
    endtask
endmodule

// *** verif/tb.sv ***
/*
 * Self-checking bench for the destination matcher: register access, sends and decisions.
 * Assumes one 20 MHz clock and the peer model on the message bus.
 */
`timescale 1ns/1ps
module tb;
    import ipi_match_pkg::*;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, msg_out_valid, msg_in_valid;
    logic        accept_pulse, discard_pulse, e;
    logic [7:0]  awaddr, araddr, my_id, lid, dst;
    logic [31:0] wdata, rdata, d;
    logic [3:0]  wstrb, model;
    logic [1:0]  bresp, rresp, r;
    ipi_msg_t    msg_out, msg_in, accepted_msg, last_out, m, x;
    int          num_errors, num_checks, sends, n0;
    logic        exp_q[$];
    ipi_msg_t    msg_q[$];
    logic [2:0]  dl[6] = '{DLV_FIXED, DLV_LOWEST, DLV_SYS_MGMT, DLV_NMI, DLV_INIT, DLV_STARTUP};

    ipi_destination_match u_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
        .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .msg_out_valid(msg_out_valid),
        .msg_out(msg_out), .msg_in_valid(msg_in_valid), .msg_in(msg_in), .accept_pulse(accept_pulse),
        .discard_pulse(discard_pulse), .accepted_msg(accepted_msg));
    peer_unit u_peer (.aclk(aclk), .msg_in_valid(msg_in_valid), .msg_in(msg_in));

    // ==========================================================
    // Checking and closing
    task automatic check(input string n, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // ==========================================================
    // AXI4-Lite master
    task automatic wr(input logic [7:0] a, input logic [31:0] dt, output logic [1:0] rs);
        @(posedge aclk);
        awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= dt; wstrb <= 4'hF; bready <= 1'b1;
        // The master waits as long as the answer takes; only the watchdog ends a hang.
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        rs = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] dt, output logic [1:0] rs);
        @(posedge aclk);
        arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        dt = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    // ==========================================================
    // Expected decisions, from the addressing models
    function automatic logic exp_acc(input ipi_msg_t q);
        if (q.shorthand == SH_SELF) return q.source_id == my_id;
        if (q.shorthand == SH_ALL_INCL) return 1'b1;
        if (q.shorthand == SH_ALL_EXCL) return q.source_id != my_id;
        if (!q.dest_mode) return q.dest == my_id || q.dest == 8'hFF;
        if (q.dest == 8'hFF) return 1'b1;
        if (model == MODEL_FLAT) return (q.dest & lid) != 8'h00;
        return q.dest[7:4] == lid[7:4] && (q.dest[3:0] & lid[3:0]) != 4'h0;
    endfunction

    // ==========================================================
    // Monitors and clock
    always @(posedge aclk) begin
        if (msg_out_valid) begin
            last_out = msg_out;
            sends++;
        end
        if (accept_pulse || discard_pulse) begin
            if (exp_q.size() == 0) check("unexpected decision", 0, 1);
            else begin
                e = exp_q.pop_front();
                x = msg_q.pop_front();
                check("accept", e, accept_pulse);
                check("single decision", !e, discard_pulse);
                if (e) check("accepted msg", x, accepted_msg);
            end
        end
    end

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    // 40000 cycles, far more than the few hundred cycles the sequence needs.
    initial begin
        #(50 * 40000);
        num_errors++;
        finish_test();
    end

    // ==========================================================
    // Main sequence
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        void'($urandom(3306));
        model = MODEL_FLAT;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFF_DEST_FMT, d, r);
        check("format reset", 32'hFFFF_FFFF, d);
        rd(8'h20, d, r);
        check("unmapped read", RESP_SLVERR, r);
        check("unmapped data", 32'h0000_0000, d);
        wr(8'h20, 32'h1, r);
        check("unmapped write", RESP_SLVERR, r);
        $display("test reset and map done");

        my_id = 8'($urandom % 255);
        wr(OFF_LOCAL_ID, {24'h0, my_id}, r);
        for (int s = 0; s < 4; s++) begin
            foreach (dl[k]) begin
                // Self and all-including-self carry fixed delivery only.
                if ((s == 1 || s == 2) && dl[k] != DLV_FIXED) continue;
                dst = 8'($urandom % 255);
                m = '0;
                m.shorthand = 2'(s);
                m.delivery = dl[k];
                m.level = (dl[k] == DLV_INIT && s == 0) ? 1'($urandom) : 1'b1;
                m.vector = 8'($urandom);
                m.dest_mode = 1'($urandom);
                d = {12'h0, m.shorthand, 2'b0, 1'($urandom), m.level, 2'b0, m.dest_mode, m.delivery, m.vector};
                m.trig_level = dl[k] == DLV_INIT && !m.level;
                m.dest_mode = (s == 0) ? m.dest_mode : 1'b0;
                m.dest = (s == 0) ? dst : 8'hFF;
                m.source_id = my_id;
                n0 = sends;
                wr(OFF_CMD_HIGH, {dst, 24'h0}, r);
                wr(OFF_CMD_LOW, d, r);
                check("write resp", RESP_OKAY, r);
                @(posedge aclk);
                check("send count", 32'(n0 + 1), 32'(sends));
                check("sent msg", m, last_out);
            end
        end
        $display("test send done");
        // Six shorthand-free, one self, one all-including and six all-excluding commands.
        rd(OFF_STATUS, d, r);
        check("sent count", 32'h0000_000E, {24'h0, d[7:0]});

        for (int ph = 0; ph < 2; ph++) begin
            model = ph ? MODEL_CLUSTER : MODEL_FLAT;
            lid = {4'($urandom % 15), 4'($urandom)};
            // The format is set before each phase's traffic, as in every enabled unit.
            wr(OFF_DEST_FMT, {model, 28'h0}, r);
            rd(OFF_DEST_FMT, d, r);
            check("format", {model, 28'hFFF_FFFF}, d);
            wr(OFF_LOGIC_DEST, {lid, 24'h0}, r);
            rd(OFF_LOGIC_DEST, d, r);
            check("logical id", {lid, 24'h0}, d);
            for (int i = 0; i < 60; i++) begin
                m = '0;
                m.delivery = DLV_FIXED;
                m.shorthand = ($urandom % 4 == 0) ? 2'($urandom) : SH_NONE;
                m.dest_mode = 1'($urandom);
                case ($urandom % 3)
                    0: m.dest = m.dest_mode ? lid : my_id;
                    1: m.dest = 8'hFF;
                    default: m.dest = {4'($urandom % 15), 4'($urandom)};
                endcase
                m.level = 1'b1;
                m.vector = 8'($urandom);
                m.source_id = ($urandom % 2) ? my_id : 8'($urandom);
                exp_q.push_back(exp_acc(m));
                msg_q.push_back(m);
                u_peer.send(m);
                if ($urandom % 2) u_peer.idle();
            end
            u_peer.idle();
            repeat (3) @(posedge aclk);
            check("pending decisions", 0, 32'(exp_q.size()));
            $display("test receive model %0d done", ph);
        end
        finish_test();
    end
endmodule
